// [inc/blsu_params.svh]
/*
 constants for the byte logic, shift and subtract unit: bus offsets, flag
 positions, reset values and operand limits. assumes 32-bit wishbone data.
*/
// Behaviour
// - subtract computes file minus accumulator in two's complement, updating carry, digit carry, zero
// - destination bit 0 sends file-op result to accumulator, 1 back to file register
// - rotate right through carry: old carry into bit 7, old bit 0 to carry
// - nibble swap exchanges bits 3:0 and 7:4, flags untouched
// - xor literal: accumulator xor 8-bit immediate into accumulator, only zero flag changes
// - xor file: accumulator xor file register, routed by destination, only zero flag changes
// - direction load with operand 6 copies accumulator to direction register, flags untouched
// - file operand address is 0 to 31 with a one-bit destination selector
`ifndef BLSU_PARAMS_SVH
`define BLSU_PARAMS_SVH

`define BLSU_ADR_ACC 4'h0
`define BLSU_ADR_STATUS 4'h4
`define BLSU_ADR_DIR 4'h8
`define BLSU_ADR_RESULT 4'hc

`define BLSU_BIT_C 0
`define BLSU_BIT_DCARRY 1
`define BLSU_BIT_Z 2

`define BLSU_RST_ACC 8'h00
`define BLSU_RST_DIR 8'hff
`define BLSU_RST_RESULT 8'h00

`define BLSU_DIR_OPERAND 5'h06
`define BLSU_FILE_ADDR_W 5

`endif

// [inc/blsu_pkg.sv]
/*
 types for the byte logic, shift and subtract unit.
 assumes blsu_params.svh is on the include path.
*/
`include "blsu_params.svh"
package blsu_pkg;
   typedef enum logic [2:0] {
      BLSU_OP_SUB_ACC_FROM_FILE = 3'h0,
      BLSU_OP_ROTATE_RIGHT_CARRY = 3'h1,
      BLSU_OP_NIBBLE_SWAP = 3'h2,
      BLSU_OP_XOR_LITERAL_ACC = 3'h3,
      BLSU_OP_XOR_ACC_FILE = 3'h4,
      BLSU_OP_DIRECTION_LOAD = 3'h5
   } blsu_op_t;

   typedef struct packed {
      blsu_op_t op;
      logic [`BLSU_FILE_ADDR_W-1:0] faddr;
      logic dest;
      logic [7:0] lit;
      logic [7:0] fdata;
   } blsu_req_t;

   typedef struct packed {
      logic z;
      logic digit_carry_flag;
      logic c;
   } blsu_flags_t;

   typedef struct packed {
      logic [7:0] value;
      blsu_flags_t flags;
      logic wr_acc;
      logic wr_file;
      logic wr_dir;
   } blsu_res_t;
endpackage

// [logic/blsu_alu.sv]
/*
 combinational result and flag logic for one operation.
 assumes the request is stable while the caller samples the result.
*/
`timescale 1ns/100ps
`include "blsu_params.svh"
module blsu_alu
   import blsu_pkg::*;
(
   input wire blsu_req_t req_i,
   input wire logic [7:0] acc_i,
   input wire blsu_flags_t flags_i,
   output blsu_res_t res_o
);
   function automatic logic is_zero(input logic [7:0] v);
      return v == 8'h00;
   endfunction

   logic [8:0] diff;
   logic [4:0] nib;

   always_comb begin
      diff = {1'b0, req_i.fdata} + {1'b0, ~acc_i} + 9'h001;
      nib = {1'b0, req_i.fdata[3:0]} + {1'b0, ~acc_i[3:0]} + 5'h01;
      res_o.value = req_i.fdata;
      res_o.flags = flags_i;
      res_o.wr_acc = 1'b0;
      res_o.wr_file = 1'b0;
      res_o.wr_dir = 1'b0;
      case (req_i.op)
         BLSU_OP_SUB_ACC_FROM_FILE: begin
            res_o.value = diff[7:0];
            res_o.flags.c = diff[8];
            res_o.flags.digit_carry_flag = nib[4];
            res_o.flags.z = is_zero(diff[7:0]);
            res_o.wr_acc = ~req_i.dest;
            res_o.wr_file = req_i.dest;
         end
         BLSU_OP_ROTATE_RIGHT_CARRY: begin
            res_o.value = {flags_i.c, req_i.fdata[7:1]};
            res_o.flags.c = req_i.fdata[0];
            res_o.wr_acc = ~req_i.dest;
            res_o.wr_file = req_i.dest;
         end
         BLSU_OP_NIBBLE_SWAP: begin
            res_o.value = {req_i.fdata[3:0], req_i.fdata[7:4]};
            res_o.wr_acc = ~req_i.dest;
            res_o.wr_file = req_i.dest;
         end
         BLSU_OP_XOR_LITERAL_ACC: begin
            res_o.value = acc_i ^ req_i.lit;
            res_o.flags.z = is_zero(acc_i ^ req_i.lit);
            res_o.wr_acc = 1'b1;
         end
         BLSU_OP_XOR_ACC_FILE: begin
            res_o.value = acc_i ^ req_i.fdata;
            res_o.flags.z = is_zero(acc_i ^ req_i.fdata);
            res_o.wr_acc = ~req_i.dest;
            res_o.wr_file = req_i.dest;
         end
         BLSU_OP_DIRECTION_LOAD: begin
            res_o.value = acc_i;
            res_o.wr_dir = (req_i.faddr == `BLSU_DIR_OPERAND);
         end
         default: begin
            res_o.value = req_i.fdata;
         end
      endcase
   end
endmodule

// [logic/blsu_top.sv]
/*
 byte logic, shift and subtract unit: executes one operation per op_valid_i
 and exposes accumulator, flags and direction register over wishbone.
 assumes the decoder supplies the addressed file register value with the
 request and accepts file_wr_o one cycle later; one clock, synchronous reset.
*/
// Added by the designer: the address map and the Wishbone register port.
`timescale 1ns/100ps
`include "blsu_params.svh"
module blsu_top
   import blsu_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic op_valid_i,
   input wire blsu_req_t req_i,
   output logic op_done_o,
   output logic file_wr_o,
   output logic [`BLSU_FILE_ADDR_W-1:0] file_addr_o,
   output logic [7:0] file_wdata_o,
   output logic [7:0] acc_o,
   output blsu_flags_t flags_o,
   output logic [7:0] dir_o
);
   logic [7:0] acc_q;
   blsu_flags_t flags_q;
   logic [7:0] dir_q;
   logic [7:0] result_q;
   logic ack_q;
   logic [31:0] rdat_q;
   logic file_wr_q;
   logic [`BLSU_FILE_ADDR_W-1:0] file_addr_q;
   logic [7:0] file_wdata_q;
   logic done_q;
   blsu_res_t res;
   logic bus_req;
   logic bus_wr;
   logic [31:0] rdat_d;

   blsu_alu u_alu (
      .req_i(req_i),
      .acc_i(acc_q),
      .flags_i(flags_q),
      .res_o(res)
   );

   // bus write lands on the edge that the master sees ack
   assign bus_req = wb_cyc_i & wb_stb_i;
   assign bus_wr = bus_req & wb_we_i & ack_q & wb_sel_i[0];

   always_comb begin
      rdat_d = 32'h0000_0000;
      case (wb_adr_i)
         `BLSU_ADR_ACC: begin
            rdat_d = {24'h00_0000, acc_q};
         end
         `BLSU_ADR_STATUS: begin
            rdat_d[`BLSU_BIT_C] = flags_q.c;
            rdat_d[`BLSU_BIT_DCARRY] = flags_q.digit_carry_flag;
            rdat_d[`BLSU_BIT_Z] = flags_q.z;
         end
         `BLSU_ADR_DIR: begin
            rdat_d = {24'h00_0000, dir_q};
         end
         `BLSU_ADR_RESULT: begin
            rdat_d = {24'h00_0000, result_q};
         end
         default: begin
            rdat_d = 32'h0000_0000;
         end
      endcase
   end

   // ack one cycle after the request, dropped the cycle after
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q <= 1'b0;
         rdat_q <= 32'h0000_0000;
      end else begin
         ack_q <= bus_req & ~ack_q;
         if (bus_req & ~ack_q) begin
            rdat_q <= rdat_d;
         end
      end
   end

   // accumulator: an operation wins over a bus write in the same cycle
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         acc_q <= `BLSU_RST_ACC;
      end else if (op_valid_i && res.wr_acc) begin
         acc_q <= res.value;
      end else if (bus_wr && wb_adr_i == `BLSU_ADR_ACC) begin
         acc_q <= wb_dat_i[7:0];
      end
   end

   // status flags
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         flags_q <= '0;
      end else if (op_valid_i) begin
         flags_q <= res.flags;
      end else if (bus_wr && wb_adr_i == `BLSU_ADR_STATUS) begin
         flags_q.c <= wb_dat_i[`BLSU_BIT_C];
         flags_q.digit_carry_flag <= wb_dat_i[`BLSU_BIT_DCARRY];
         flags_q.z <= wb_dat_i[`BLSU_BIT_Z];
      end
   end

   // port direction register
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dir_q <= `BLSU_RST_DIR;
      end else if (op_valid_i && res.wr_dir) begin
         dir_q <= res.value;
      end else if (bus_wr && wb_adr_i == `BLSU_ADR_DIR) begin
         dir_q <= wb_dat_i[7:0];
      end
   end

   // file write-back and last result
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         file_wr_q <= 1'b0;
         file_addr_q <= '0;
         file_wdata_q <= 8'h00;
         result_q <= `BLSU_RST_RESULT;
         done_q <= 1'b0;
      end else begin
         file_wr_q <= op_valid_i & res.wr_file;
         done_q <= op_valid_i;
         if (op_valid_i) begin
            file_addr_q <= req_i.faddr;
            file_wdata_q <= res.value;
            result_q <= res.value;
         end
      end
   end

   assign wb_ack_o = ack_q;
   assign wb_dat_o = rdat_q;
   assign op_done_o = done_q;
   assign file_wr_o = file_wr_q;
   assign file_addr_o = file_addr_q;
   assign file_wdata_o = file_wdata_q;
   assign acc_o = acc_q;
   assign flags_o = flags_q;
   assign dir_o = dir_q;

   // checks
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   logic is_sub;
   logic is_rot;
   logic is_swap;
   logic is_xlit;
   logic is_xfile;
   logic is_dir;
   assign is_sub = op_valid_i && req_i.op == BLSU_OP_SUB_ACC_FROM_FILE;
   assign is_rot = op_valid_i && req_i.op == BLSU_OP_ROTATE_RIGHT_CARRY;
   assign is_swap = op_valid_i && req_i.op == BLSU_OP_NIBBLE_SWAP;
   assign is_xlit = op_valid_i && req_i.op == BLSU_OP_XOR_LITERAL_ACC;
   assign is_xfile = op_valid_i && req_i.op == BLSU_OP_XOR_ACC_FILE;
   assign is_dir = op_valid_i && req_i.op == BLSU_OP_DIRECTION_LOAD;

   AST_SUB_VALUE: assert property (is_sub && !req_i.dest |=>
      acc_q == 8'($past(req_i.fdata) - $past(acc_q)))
      else $error("subtract result wrong");
   AST_SUB_FLAGS: assert property (is_sub |=>
      flags_q.c == ($past(req_i.fdata) >= $past(acc_q)) &&
      flags_q.digit_carry_flag == ($past(req_i.fdata[3:0]) >= $past(acc_q[3:0])))
      else $error("subtract carry flags wrong");
   AST_DEST_FILE: assert property ((is_sub || is_rot || is_swap || is_xfile) && req_i.dest |=>
      file_wr_o && $stable(acc_q) && file_wdata_o == result_q ##1 !file_wr_o || $past(op_valid_i))
      else $error("file destination not honoured");
   AST_DEST_ACC: assert property ((is_sub || is_rot || is_swap || is_xfile) && !req_i.dest |=>
      !file_wr_o && acc_q == result_q)
      else $error("accumulator destination not honoured");
   AST_ROTATE: assert property (is_rot |=>
      result_q == {$past(flags_q.c), $past(req_i.fdata[7:1])} && flags_q.c == $past(req_i.fdata[0]) &&
      $stable(flags_q.z) && $stable(flags_q.digit_carry_flag))
      else $error("rotate right wrong");
   AST_SWAP: assert property (is_swap |=>
      result_q == {$past(req_i.fdata[3:0]), $past(req_i.fdata[7:4])} && $stable(flags_q))
      else $error("nibble swap wrong");
   AST_XOR_LIT: assert property (is_xlit |=>
      acc_q == ($past(acc_q) ^ $past(req_i.lit)) && !file_wr_o &&
      $stable(flags_q.c) && $stable(flags_q.digit_carry_flag))
      else $error("xor literal wrong");
   AST_XOR_FILE: assert property (is_xfile |=>
      result_q == ($past(acc_q) ^ $past(req_i.fdata)) &&
      $stable(flags_q.c) && $stable(flags_q.digit_carry_flag))
      else $error("xor file wrong");
   AST_DIR_LOAD: assert property (is_dir |=>
      dir_o == ($past(req_i.faddr) == `BLSU_DIR_OPERAND ? $past(acc_q) : $past(dir_q)) &&
      $stable(flags_q) && $stable(acc_q))
      else $error("direction load wrong");
   AST_FILE_ADDR: assert property (file_wr_o |->
      $past(op_valid_i) && file_addr_o == $past(req_i.faddr))
      else $error("file address not from request");
   AST_ZERO: assert property (is_sub || is_xlit || is_xfile |=>
      flags_q.z == (result_q == 8'h00))
      else $error("zero flag wrong");
   AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held over two cycles");

   COV_SUB_BORROW: cover property (is_sub ##1 !flags_q.c);
   COV_ROT_FILE: cover property (is_rot && req_i.dest ##1 file_wr_o);
   COV_XOR_ZERO: cover property (is_xlit ##1 flags_q.z);
   COV_DIR: cover property (is_dir && req_i.faddr == `BLSU_DIR_OPERAND);
endmodule

// [bench/blsu_file_model.sv]
/*
 file register array on the decoder side of the unit.
 assumes the unit's file write lands at the next rising edge.
*/
`timescale 1ns/100ps
module blsu_file_model (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [4:0] rd_addr_i,
   input wire logic wr_i,
   input wire logic [4:0] wr_addr_i,
   input wire logic [7:0] wr_data_i,
   output logic [7:0] rd_data_o
);
   logic [7:0] mem_q [32];
   assign rd_data_o = mem_q[rd_addr_i];
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         for (int i = 0; i < 32; i++) mem_q[i] <= 8'(i * 37 + 3);
      end else if (wr_i) begin
         mem_q[wr_addr_i] <= wr_data_i;
      end
   end
endmodule

// [bench/test_byte_logic_shift_subtract_unit.sv]
/*
 testbench: bus and operation tasks with a file register model.
 assumes registered ack one cycle after the request.
*/
`timescale 1ns/100ps
`include "blsu_params.svh"
module test_byte_logic_shift_subtract_unit
   import blsu_pkg::*;
;
   logic clk, rst, cyc, stb, we, ack, valid, dest, done, fwr, e_c, e_dcy, e_z, wf;
   logic [3:0] adr, sel;
   logic [31:0] wdat, rdat;
   logic [4:0] fa, faddr_o;
   logic [7:0] lit, fdata, fwdata, acc, dir, e_acc, e_dir;
   logic [7:0] sh [32];
   blsu_op_t op_q;
   blsu_req_t req;
   blsu_flags_t flags;
   int fail_count = 0;
   int checked = 0;
   assign req = {op_q, fa, dest, lit, fdata};
   blsu_top DUT (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .op_valid_i(valid), .req_i(req),
      .op_done_o(done), .file_wr_o(fwr), .file_addr_o(faddr_o), .file_wdata_o(fwdata), .acc_o(acc),
      .flags_o(flags), .dir_o(dir));
   blsu_file_model model (.clk_i(clk), .rst_i(rst), .rd_addr_i(fa), .wr_i(fwr), .wr_addr_i(faddr_o),
      .wr_data_i(fwdata), .rd_data_o(fdata));
   initial begin
      clk = 0;
      forever #5 clk = ~clk;
   end
   task automatic stop_test;
      if (fail_count == 0 && checked > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [31:0] e);
      @(posedge clk);
      cyc <= 1; stb <= 1; we <= w; adr <= a; wdat <= d; sel <= 4'hf;
      @(posedge clk);
      while (ack !== 1'b1) @(posedge clk);
      if (!w) chk(rdat, e);
      cyc <= 0; stb <= 0; we <= 0;
      @(posedge clk);
   endtask
   task automatic op(input blsu_op_t o, input logic [4:0] a, input logic d, input logic [7:0] k);
      logic [7:0] f, r;
      f = sh[a];
      r = f;
      wf = 0;
      @(posedge clk);
      valid <= 1; op_q <= o; fa <= a; dest <= d; lit <= k;
      @(posedge clk);
      valid <= 0;
      case (o)
         BLSU_OP_SUB_ACC_FROM_FILE: begin
            r = f - e_acc; e_c = f >= e_acc; e_dcy = f[3:0] >= e_acc[3:0]; e_z = r == 8'h00;
         end
         BLSU_OP_ROTATE_RIGHT_CARRY: begin
            r = {e_c, f[7:1]}; e_c = f[0];
         end
         BLSU_OP_NIBBLE_SWAP: r = {f[3:0], f[7:4]};
         BLSU_OP_XOR_LITERAL_ACC: begin
            r = e_acc ^ k; e_z = r == 8'h00;
         end
         BLSU_OP_XOR_ACC_FILE: begin
            r = e_acc ^ f; e_z = r == 8'h00;
         end
         default: if (a == `BLSU_DIR_OPERAND) e_dir = e_acc;
      endcase
      if (o == BLSU_OP_XOR_LITERAL_ACC || o == BLSU_OP_DIRECTION_LOAD || !d) begin
         if (o != BLSU_OP_DIRECTION_LOAD) e_acc = r;
      end else begin
         sh[a] = r; wf = 1;
      end
      #1;
      chk(done, 1);
      chk(fwr, wf);
      if (wf) chk({faddr_o, fwdata}, {a, r});
      chk(acc, e_acc);
      chk(flags, {e_z, e_dcy, e_c});
      chk(dir, e_dir);
   endtask
   initial begin
      repeat (5000) @(posedge clk);
      fail_count++;
      stop_test;
   end
   initial begin
      rst = 1; cyc = 0; stb = 0; we = 0; adr = 0; sel = 0; wdat = 0; valid = 0; dest = 0; lit = 0; fa = 0;
      op_q = BLSU_OP_SUB_ACC_FROM_FILE;
      e_acc = 0; e_c = 0; e_dcy = 0; e_z = 0; e_dir = `BLSU_RST_DIR;
      for (int i = 0; i < 32; i++) sh[i] = 8'(i * 37 + 3);
      repeat (10) @(posedge clk);
      rst <= 0;
      wb(0, `BLSU_ADR_ACC, 0, `BLSU_RST_ACC);
      wb(0, `BLSU_ADR_STATUS, 0, 0);
      wb(0, `BLSU_ADR_DIR, 0, `BLSU_RST_DIR);
      wb(0, `BLSU_ADR_RESULT, 0, `BLSU_RST_RESULT);
      wb(0, 4'h2, 0, 0);
      wb(1, `BLSU_ADR_ACC, 32'h5a, 0);
      e_acc = 8'h5a;
      wb(0, `BLSU_ADR_ACC, 0, 32'h5a);
      op(BLSU_OP_SUB_ACC_FROM_FILE, 5'd1, 0, 0);
      op(BLSU_OP_SUB_ACC_FROM_FILE, 5'd31, 1, 0);
      op(BLSU_OP_XOR_LITERAL_ACC, 5'd0, 0, e_acc);
      op(BLSU_OP_SUB_ACC_FROM_FILE, 5'd0, 0, 0);
      op(BLSU_OP_SUB_ACC_FROM_FILE, 5'd0, 1, 0);
      op(BLSU_OP_ROTATE_RIGHT_CARRY, 5'd2, 0, 0);
      op(BLSU_OP_ROTATE_RIGHT_CARRY, 5'd2, 1, 0);
      wb(1, `BLSU_ADR_STATUS, 32'h0, 0);
      e_c = 0; e_dcy = 0; e_z = 0;
      op(BLSU_OP_ROTATE_RIGHT_CARRY, 5'd3, 0, 0);
      op(BLSU_OP_NIBBLE_SWAP, 5'd31, 0, 0);
      op(BLSU_OP_NIBBLE_SWAP, 5'd4, 1, 0);
      op(BLSU_OP_XOR_ACC_FILE, 5'd5, 0, 0);
      op(BLSU_OP_XOR_ACC_FILE, 5'd5, 1, 0);
      op(BLSU_OP_XOR_LITERAL_ACC, 5'd0, 1, 8'hff);
      op(BLSU_OP_DIRECTION_LOAD, 5'd6, 0, 0);
      wb(1, `BLSU_ADR_ACC, 32'h3c, 0);
      e_acc = 8'h3c;
      op(BLSU_OP_DIRECTION_LOAD, 5'd7, 0, 0);
      wb(0, `BLSU_ADR_DIR, 0, {24'h0, e_dir});
      wb(0, `BLSU_ADR_RESULT, 0, {24'h0, e_acc});
      // mid-run reset brings every register back to its reset value
      rst <= 1;
      repeat (2) @(posedge clk);
      rst <= 0;
      wb(0, `BLSU_ADR_ACC, 0, `BLSU_RST_ACC);
      wb(0, `BLSU_ADR_STATUS, 0, 0);
      wb(0, `BLSU_ADR_DIR, 0, `BLSU_RST_DIR);
      wb(0, `BLSU_ADR_RESULT, 0, `BLSU_RST_RESULT);
      stop_test;
   end
endmodule
